// [inc/mapt_params.svh]
// Purpose: constants of the multiturn absolute position tracker
// Assumes: 50 MHz mclk, plain register port with 16-bit addresses
// Notes: offsets are plain port addresses, one register each
// Function
// - Mode 0: incremental, no retention, unlimited travel
// - Mode 1: linear multiturn, position retained
// - Mode 2: count wraps within zero..upper limit
// - Mode 3: single-turn, overflow raises alarm
// - Code 5 with healthy battery clears overflow and first-use alarms, 3 s timeout
// - Code 9 when homed zeroes count, clears alarm but not low battery
// - Clockwise counts down, counter-clockwise counts up
// - Revolution count wraps at 16-bit signed ends
// - Single-turn range follows encoder resolution
// - Mode 3 target window shifted by offset
// - Multiturn clear keeps single-turn position
// - Mode 1 with new battery flags invalid
// - Homed and healthy battery clears first-use
// - Below 3.2 V alarms until restart
// - Below 2.5 V needs homing and clear
// - Alarm drives alarm output and halts motion
`ifndef MAPT_PARAMS_SVH
`define MAPT_PARAMS_SVH
`define MAPT_A_MODE 16'h2015
`define MAPT_A_LIMIT 16'h2016
`define MAPT_A_STATUS 16'h2017
`define MAPT_A_REV 16'h2018
`define MAPT_A_SPOS 16'h2019
`define MAPT_A_HOFF 16'h201A
`define MAPT_A_TGT 16'h201B
`define MAPT_M_INC 16'h0000
`define MAPT_M_LIN 16'h0001
`define MAPT_M_ROT 16'h0002
`define MAPT_M_SGL 16'h0003
`define MAPT_M_CLRA 16'h0005
`define MAPT_M_CLRM 16'h0009
`define MAPT_MODE_RST 16'h0000
`define MAPT_LIMIT_RST 16'h0000
`define MAPT_REV_ZERO 16'h0000
`define MAPT_REV_ONE 16'h0001
`define MAPT_REV_MAX 16'h7FFF
`define MAPT_REV_MIN 16'h8000
`define MAPT_MAX17 33'h00001FFFF
`define MAPT_MAX23 33'h0007FFFFF
`define MAPT_MASK17 23'h01FFFF
`define MAPT_CLR_TIME_MS 3000
`define MAPT_CLK_KHZ 50000
`define MAPT_ST_ALARM 0
`define MAPT_ST_INVALID 1
`define MAPT_ST_LOW 2
`define MAPT_ST_DEAD 3
`define MAPT_ST_OVF 4
`define MAPT_ST_FAIL 5
`define MAPT_ST_BUSY 6
`define MAPT_ST_TGTOK 7
`endif

// [inc/mapt_pkg.sv]
// Purpose: types of the multiturn absolute position tracker
// Assumes: nothing beyond the params header
// Notes: state of the alarm-clear sequencer
package mapt_pkg;
	typedef enum logic [1:0] {
		MAPT_CLR_IDLE,
		MAPT_CLR_WAIT,
		MAPT_CLR_FAIL
	} mapt_clr_t;
	typedef logic signed [15:0] mapt_rev_t;
endpackage

// [rtl/mapt_sync.sv]
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are slow levels
// Notes: first stage is read only by the second
`timescale 1ns/10ps
module mapt_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= pin_in;
			sync_q <= meta_q;
		end
	end
	assign sync_out = sync_q;
endmodule

// [rtl/mapt_tracker.sv]
// Purpose: revolution count, mode control and encoder alarm
// Assumes: rev pulses and home_done come from logic on mclk
// Notes: battery pins are asynchronous and synchronised here
`timescale 1ns/10ps
`include "mapt_params.svh"
module mapt_tracker
	import mapt_pkg::*;
#(
	parameter int CLR_TIMEOUT_CYC = `MAPT_CLR_TIME_MS * `MAPT_CLK_KHZ
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [15:0] addr,
	input wire logic [31:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [31:0] rdata_q,
	input wire logic rev_ccw,
	input wire logic rev_cw,
	input wire logic [22:0] st_pos,
	input wire logic res23,
	input wire logic home_done,
	input wire logic batt_low_pin,
	input wire logic batt_dead_pin,
	input wire logic batt_new_pin,
	output logic alarm_q,
	output logic halt_q,
	output logic retain_q,
	output logic invalid_q
);
	logic [2:0] pins_s;
	logic batt_low_s;
	logic batt_dead_s;
	logic batt_new_s;
	mapt_sync #(.W(3)) u_sync (
		.mclk(mclk),
		.nrst(nrst),
		.pin_in({batt_new_pin, batt_dead_pin, batt_low_pin}),
		.sync_out(pins_s)
	);
	assign batt_low_s = pins_s[0];
	assign batt_dead_s = pins_s[1];
	assign batt_new_s = pins_s[2];

	logic [15:0] mode_q, mode_d, mt_q, mt_d, lim_q, lim_d;
	mapt_rev_t rev_q, rev_d;
	logic [31:0] hoff_q, hoff_d, tgt_q, tgt_d, tmr_q, tmr_d;
	logic ok_q, ok_d, fail_q, fail_d, pend_q, pend_d;
	logic first_q, first_d, low_q, low_d, dead_q, dead_d, ovf_q, ovf_d;
	logic alarm_d, retain_d;
	mapt_clr_t clr_q, clr_d;
	logic step_up, step_dn, bfault, mode_wr, wr9;
	logic [15:0] wmode;
	logic signed [32:0] diff;

	assign step_up = rev_ccw && !rev_cw;
	assign step_dn = rev_cw && !rev_ccw;
	assign bfault = batt_low_s || batt_dead_s;
	assign wmode = wdata[15:0];
	assign mode_wr = we && (addr == `MAPT_A_MODE);
	assign wr9 = mode_wr && (wmode == `MAPT_M_CLRM);
	assign diff = $signed({tgt_q[31], tgt_q}) - $signed({hoff_q[31], hoff_q});

	always_comb begin
		mode_d = mode_q;
		mt_d = mt_q;
		lim_d = lim_q;
		rev_d = rev_q;
		hoff_d = hoff_q;
		tgt_d = tgt_q;
		tmr_d = tmr_q;
		fail_d = fail_q;
		pend_d = pend_q;
		first_d = first_q;
		low_d = low_q;
		dead_d = dead_q;
		ovf_d = ovf_q;
		clr_d = clr_q;
		// Clear sequencer: switch back to multiturn once all alarms are gone
		if (clr_q == MAPT_CLR_WAIT) begin
			if (!(first_q || low_q || dead_q || ovf_q)) begin
				mode_d = mt_q;
				clr_d = MAPT_CLR_IDLE;
			end else if (tmr_q >= 32'(CLR_TIMEOUT_CYC - 1)) begin
				fail_d = 1'b1;
				clr_d = MAPT_CLR_FAIL;
			end else begin
				tmr_d = tmr_q + 32'd1;
			end
		end
		// First-use alarm ends once homed with a healthy battery
		if (first_q && home_done && !bfault) begin
			first_d = 1'b0;
		end
		// Revolution tracking by mode
		unique case (mode_q)
			`MAPT_M_SGL: begin
				// Overflow is flagged below, after the clear codes
				rev_d = rev_q;
			end
			`MAPT_M_ROT: begin
				if (step_up) begin
					rev_d = (rev_q >= $signed(lim_q)) ? `MAPT_REV_ZERO : rev_q + `MAPT_REV_ONE;
				end else if (step_dn) begin
					rev_d = (rev_q <= $signed(`MAPT_REV_ZERO)) ? $signed(lim_q) : rev_q - `MAPT_REV_ONE;
				end
			end
			default: begin
				// Natural 16-bit wrap gives +32767 -> -32768 -> -32767
				if (step_up) begin
					rev_d = rev_q + `MAPT_REV_ONE;
				end else if (step_dn) begin
					rev_d = rev_q - `MAPT_REV_ONE;
				end
			end
		endcase
		// Register writes; unknown mode codes are ignored
		if (mode_wr) begin
			unique case (wmode)
				`MAPT_M_INC, `MAPT_M_SGL: begin
					mode_d = wmode;
					clr_d = MAPT_CLR_IDLE;
				end
				`MAPT_M_LIN, `MAPT_M_ROT: begin
					mode_d = wmode;
					mt_d = wmode;
					clr_d = MAPT_CLR_IDLE;
					if (wmode == `MAPT_M_LIN && pend_q) begin
						first_d = 1'b1;
						pend_d = 1'b0;
					end
				end
				`MAPT_M_CLRA: begin
					mode_d = wmode;
					clr_d = MAPT_CLR_WAIT;
					tmr_d = '0;
					fail_d = 1'b0;
					if (!bfault) begin
						ovf_d = 1'b0;
						first_d = 1'b0;
					end
				end
				`MAPT_M_CLRM: begin
					mode_d = wmode;
					clr_d = MAPT_CLR_WAIT;
					tmr_d = '0;
					fail_d = 1'b0;
					// Clearing unhomed would misplace the origin; it just times out
					if (home_done) begin
						rev_d = `MAPT_REV_ZERO;
						ovf_d = 1'b0;
						if (!bfault) begin
							first_d = 1'b0;
						end
						if (!batt_dead_s) begin
							dead_d = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (we && addr == `MAPT_A_LIMIT) begin
			lim_d = wdata[15:0];
		end
		if (we && addr == `MAPT_A_HOFF) begin
			hoff_d = wdata;
		end
		if (we && addr == `MAPT_A_TGT) begin
			tgt_d = wdata;
		end
		// Alarm sets last so a set beats a clear in the same cycle
		if ((mode_q == `MAPT_M_SGL) && (step_up || step_dn)) begin
			ovf_d = 1'b1;
		end
		if (batt_low_s) begin
			low_d = 1'b1;
		end
		if (batt_dead_s) begin
			dead_d = 1'b1;
		end
		if (batt_new_s) begin
			pend_d = 1'b1;
		end
		alarm_d = first_d || low_d || dead_d || ovf_d;
		retain_d = (mode_d == `MAPT_M_LIN) || (mode_d == `MAPT_M_ROT);
		// Target window; resolution picks the single-turn span
		ok_d = (mode_q == `MAPT_M_SGL) && !diff[32] &&
			(diff <= (res23 ? `MAPT_MAX23 : `MAPT_MAX17));
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			mode_q <= `MAPT_MODE_RST;
			mt_q <= `MAPT_M_LIN;
			lim_q <= `MAPT_LIMIT_RST;
			rev_q <= `MAPT_REV_ZERO;
			hoff_q <= '0;
			tgt_q <= '0;
			tmr_q <= '0;
			ok_q <= 1'b0;
			fail_q <= 1'b0;
			pend_q <= 1'b0;
			first_q <= 1'b0;
			low_q <= 1'b0;
			dead_q <= 1'b0;
			ovf_q <= 1'b0;
			clr_q <= MAPT_CLR_IDLE;
			alarm_q <= 1'b0;
			halt_q <= 1'b0;
			retain_q <= 1'b0;
			invalid_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			mt_q <= mt_d;
			lim_q <= lim_d;
			rev_q <= rev_d;
			hoff_q <= hoff_d;
			tgt_q <= tgt_d;
			tmr_q <= tmr_d;
			ok_q <= ok_d;
			fail_q <= fail_d;
			pend_q <= pend_d;
			first_q <= first_d;
			low_q <= low_d;
			dead_q <= dead_d;
			ovf_q <= ovf_d;
			clr_q <= clr_d;
			alarm_q <= alarm_d;
			halt_q <= alarm_d;
			retain_q <= retain_d;
			invalid_q <= first_d;
		end
	end

	logic [31:0] rdata_d;
	logic [31:0] status;
	always_comb begin
		status = '0;
		status[`MAPT_ST_ALARM] = alarm_q;
		status[`MAPT_ST_INVALID] = first_q;
		status[`MAPT_ST_LOW] = low_q;
		status[`MAPT_ST_DEAD] = dead_q;
		status[`MAPT_ST_OVF] = ovf_q;
		status[`MAPT_ST_FAIL] = fail_q;
		status[`MAPT_ST_BUSY] = (clr_q == MAPT_CLR_WAIT);
		status[`MAPT_ST_TGTOK] = ok_q;
		rdata_d = '0;
		if (re) begin
			unique case (addr)
				`MAPT_A_MODE: rdata_d = {16'h0000, mode_q};
				`MAPT_A_LIMIT: rdata_d = {16'h0000, lim_q};
				`MAPT_A_STATUS: rdata_d = status;
				`MAPT_A_REV: rdata_d = {{16{rev_q[15]}}, rev_q};
				`MAPT_A_SPOS: rdata_d = {9'h000, res23 ? st_pos : (st_pos & `MAPT_MASK17)};
				`MAPT_A_HOFF: rdata_d = hoff_q;
				`MAPT_A_TGT: rdata_d = tgt_q;
				default: rdata_d = '0;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_inc_noret;
		(mode_q == `MAPT_M_INC) |-> !retain_q;
	endproperty
	a_inc_noret: assert property (p_inc_noret) else $error("incremental retains");
	property p_lin_ret;
		(mode_q == `MAPT_M_LIN) |-> retain_q;
	endproperty
	a_lin_ret: assert property (p_lin_ret) else $error("linear not retained");
	property p_rot_top;
		(mode_q == `MAPT_M_ROT) && step_up && !we && (rev_q == $signed(lim_q))
			|=> (rev_q == `MAPT_REV_ZERO);
	endproperty
	a_rot_top: assert property (p_rot_top) else $error("rotary no wrap at top");
	property p_rot_bot;
		(mode_q == `MAPT_M_ROT) && step_dn && !we && (rev_q == `MAPT_REV_ZERO)
			|=> (rev_q == $signed($past(lim_q)));
	endproperty
	a_rot_bot: assert property (p_rot_bot) else $error("rotary no wrap at zero");
	property p_sgl_ovf;
		(mode_q == `MAPT_M_SGL) && (step_up || step_dn) |=> ovf_q && alarm_q;
	endproperty
	a_sgl_ovf: assert property (p_sgl_ovf) else $error("overflow not alarmed");
	property p_clr_done;
		(clr_q == MAPT_CLR_WAIT) && !alarm_q && !we |=> (mode_q == $past(mt_q));
	endproperty
	a_clr_done: assert property (p_clr_done) else $error("mode not restored");
	property p_clr9;
		wr9 && home_done && !rev_ccw && !rev_cw |=> (rev_q == `MAPT_REV_ZERO) && !ovf_q;
	endproperty
	a_clr9: assert property (p_clr9) else $error("count not zeroed");
	property p_cw_down;
		(mode_q == `MAPT_M_LIN) && step_dn && !we |=> (rev_q == $past(rev_q) - `MAPT_REV_ONE);
	endproperty
	a_cw_down: assert property (p_cw_down) else $error("cw not negative");
	property p_wrap;
		(mode_q == `MAPT_M_LIN) && step_up && !we && (rev_q == `MAPT_REV_MAX)
			|=> (rev_q == `MAPT_REV_MIN);
	endproperty
	a_wrap: assert property (p_wrap) else $error("no wrap at top");
	property p_first;
		mode_wr && (wmode == `MAPT_M_LIN) && pend_q |=> first_q && invalid_q && alarm_q;
	endproperty
	a_first: assert property (p_first) else $error("first use not flagged");
	property p_low;
		batt_low_s |=> low_q ##1 low_q;
	endproperty
	a_low: assert property (p_low) else $error("low battery not held");
	property p_dead;
		dead_q && !(wr9 && home_done) |=> dead_q;
	endproperty
	a_dead: assert property (p_dead) else $error("deep alarm dropped");
	property p_halt;
		(halt_q == alarm_q) && (alarm_q == (first_q || low_q || dead_q || ovf_q));
	endproperty
	a_halt: assert property (p_halt) else $error("alarm output mismatch");
	c_wrap: cover property (p_wrap);
	c_clr_ok: cover property ((clr_q == MAPT_CLR_WAIT) ##1 (clr_q == MAPT_CLR_IDLE));
	c_first: cover property (first_q ##1 !first_q);
endmodule

// [verif/mapt_enc_model.sv]
// Purpose: encoder-side model giving revolution pulses and single-turn data
// Assumes: one clock shared with the tracker
// Notes: pulses are registered so they leave just after an edge
`timescale 1ns/10ps
module mapt_enc_model #(
	parameter logic [22:0] SPOS = 23'h5A5A5
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic go,
	input wire logic ccw,
	output logic rev_ccw,
	output logic rev_cw,
	output logic [22:0] st_pos
);
	logic ccw_d;
	logic cw_d;
	// Only one direction per crossing, never both at once
	always_comb begin
		ccw_d = go & ccw;
		cw_d = go & ~ccw;
	end
	always_ff @(posedge mclk) begin
		rev_ccw <= nrst & ccw_d;
		rev_cw <= nrst & cw_d;
	end
	// Held fixed so any change after a clear shows up as an error
	assign st_pos = SPOS;
endmodule

// [verif/testbench.sv]
// Purpose: self-checking bench of the position tracker
// Assumes: clear timeout shortened to 20 cycles
// Notes: battery pins driven here, pulses from the encoder model
`timescale 1ns/10ps
`include "mapt_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
	$display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module testbench;
	logic mclk = 0;
	logic nrst = 0;
	logic [15:0] addr = 0;
	logic [31:0] wdata = 0;
	logic we = 0;
	logic re = 0;
	logic [31:0] rdata_q;
	logic rev_ccw, rev_cw, alarm_q, halt_q, retain_q, invalid_q;
	logic [22:0] st_pos;
	logic go = 0, ccw = 0, res23 = 1, home_done = 1;
	logic blow = 0, bdead = 0, bnew = 0;
	logic [31:0] d;
	int error_cnt = 0;
	int num_checks = 0;
	mapt_enc_model enc (.mclk(mclk), .nrst(nrst), .go(go), .ccw(ccw),
		.rev_ccw(rev_ccw), .rev_cw(rev_cw), .st_pos(st_pos));
	mapt_tracker #(.CLR_TIMEOUT_CYC(20)) dut (.mclk(mclk), .nrst(nrst), .addr(addr),
		.wdata(wdata), .we(we), .re(re), .rdata_q(rdata_q), .rev_ccw(rev_ccw),
		.rev_cw(rev_cw), .st_pos(st_pos), .res23(res23), .home_done(home_done),
		.batt_low_pin(blow), .batt_dead_pin(bdead), .batt_new_pin(bnew),
		.alarm_q(alarm_q), .halt_q(halt_q), .retain_q(retain_q), .invalid_q(invalid_q));
	initial begin
		forever #10 mclk = ~mclk;
	end
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		we <= 1;
		@(posedge mclk);
		we <= 0;
	endtask
	task rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		re <= 1;
		@(posedge mclk);
		re <= 0;
		#1 v = rdata_q;
	endtask
	task turn(input int n, input logic c);
		repeat (n) begin
			@(posedge mclk);
			go <= 1;
			ccw <= c;
		end
		@(posedge mclk);
		go <= 0;
		repeat (3) @(posedge mclk);
	endtask
	// Bounded wait, the final compare counts a miss
	task wait_alarm(input logic v);
		for (int i = 0; i < 20 && alarm_q !== v; i++) begin
			@(posedge mclk);
			#1;
		end
		`CHK(alarm_q, v)
	endtask
	task restart;
		@(posedge mclk);
		nrst <= 0;
		repeat (3) @(posedge mclk);
		nrst <= 1;
	endtask
	initial begin
		repeat (90000) @(posedge mclk);
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge mclk);
		nrst <= 1;
		rd(`MAPT_A_MODE, d); `CHK(d, 32'h0)
		rd(16'h3000, d); `CHK(d, 32'h0)
		wr(`MAPT_A_MODE, 32'h1);
		@(posedge mclk); #1 `CHK(retain_q, 1'b1)
		turn(3, 1);
		turn(1, 0);
		rd(`MAPT_A_REV, d); `CHK(d, 32'h2)
		rd(`MAPT_A_REV, d); `CHK(d, 32'h2)
		wr(`MAPT_A_MODE, 32'h9);
		repeat (4) @(posedge mclk);
		rd(`MAPT_A_REV, d); `CHK(d, 32'h0)
		rd(`MAPT_A_MODE, d); `CHK(d, 32'h1)
		rd(`MAPT_A_SPOS, d); `CHK(d, 32'h5A5A5)
		@(posedge mclk);
		res23 <= 0;
		rd(`MAPT_A_SPOS, d); `CHK(d, 32'h1A5A5)
		@(posedge mclk);
		res23 <= 1;
		// Long run of back-to-back crossings wraps past the positive end to the negative end
		turn(32768, 1);
		rd(`MAPT_A_REV, d); `CHK(d, 32'hFFFF8000)
		turn(1, 0);
		rd(`MAPT_A_REV, d); `CHK(d, 32'h7FFF)
		wr(`MAPT_A_LIMIT, 32'h3);
		wr(`MAPT_A_MODE, 32'h2);
		wr(`MAPT_A_MODE, 32'h9);
		repeat (4) @(posedge mclk);
		rd(`MAPT_A_MODE, d); `CHK(d, 32'h2)
		turn(1, 0);
		rd(`MAPT_A_REV, d); `CHK(d, 32'h3)
		turn(1, 1);
		rd(`MAPT_A_REV, d); `CHK(d, 32'h0)
		wr(`MAPT_A_MODE, 32'h3);
		// Target window is offset by the homing offset
		wr(`MAPT_A_HOFF, 32'h00002710);
		wr(`MAPT_A_TGT, 32'h0080270F);
		rd(`MAPT_A_STATUS, d); `CHK(d[7], 1'b1)
		wr(`MAPT_A_TGT, 32'h00802710);
		rd(`MAPT_A_STATUS, d); `CHK(d[7], 1'b0)
		wr(`MAPT_A_TGT, 32'h0000270F);
		rd(`MAPT_A_STATUS, d); `CHK(d[7], 1'b0)
		turn(1, 1);
		wait_alarm(1);
		`CHK(halt_q, 1'b1)
		rd(`MAPT_A_STATUS, d); `CHK(d[4], 1'b1)
		wr(`MAPT_A_MODE, 32'h5);
		wait_alarm(0);
		repeat (2) @(posedge mclk);
		rd(`MAPT_A_MODE, d); `CHK(d, 32'h2)
		blow <= 1;
		wait_alarm(1);
		wr(`MAPT_A_MODE, 32'h5);
		repeat (30) @(posedge mclk);
		rd(`MAPT_A_STATUS, d); `CHK(d[5], 1'b1)
		rd(`MAPT_A_MODE, d); `CHK(d, 32'h5)
		blow <= 0;
		restart();
		repeat (4) @(posedge mclk);
		#1 `CHK(alarm_q, 1'b0)
		bdead <= 1;
		wait_alarm(1);
		bdead <= 0;
		repeat (6) @(posedge mclk);
		#1 `CHK(alarm_q, 1'b1)
		wr(`MAPT_A_MODE, 32'h9);
		wait_alarm(0);
		// Fresh battery with the axis not yet homed
		restart();
		home_done <= 0;
		bnew <= 1;
		repeat (5) @(posedge mclk);
		bnew <= 0;
		wr(`MAPT_A_MODE, 32'h1);
		wait_alarm(1);
		`CHK(invalid_q, 1'b1)
		home_done <= 1;
		wait_alarm(0);
		`CHK(invalid_q, 1'b0)
		print_verdict();
	end
endmodule
